// >>> pls_top.sv
// phy link status register with avalon-mm slave and event interrupt
//
// Function
// R1: status register at index 0x01, read-only 16 bits, reset value 0x7849.
// R2: bits 14 and 13 read one: 100 Mb/s full and half duplex.
// R3: bits 12 and 11 read one: 10 Mb/s full and half duplex.
// R4: bit 15 and bits 10:7 read zero; software preserves them.
// R5: bit 6 reads one: preamble-free management frames accepted.
// R6: bit 5 zero after reset, set once auto-negotiation finishes.
// R7: bit 4 latches remote fault until read; the read clears it.
// R8: bit 3 reads one: auto-negotiation ability.
// R9: bit 2 zero after reset, one while a valid link exists.
// R10: bit 1 latches jabber until read; the read clears it.
// R11: bit 0 reads one: extended register set present.
// R12: read returns latched bits then clears; still-present condition re-sets.
//
// Chosen here: the Avalon-MM interface to the registers.
`default_nettype none
module pls_top (
    input wire logic clk, // system clock, 250 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes state when low
    input wire logic [pls_pkg::PLS_ADDR_W-1:0] address, // byte address
    input wire logic read, // avalon read request
    input wire logic write, // avalon write request
    input wire logic [pls_pkg::PLS_DATA_W-1:0] writedata, // write data
    input wire logic [pls_pkg::PLS_BE_W-1:0] byteenable, // byte lanes
    output logic [pls_pkg::PLS_DATA_W-1:0] readdata, // read data
    output logic waitrequest, // low for one cycle to end a request
    output logic irq, // level interrupt
    input wire logic linkUpPin, // line logic: valid link level
    input wire logic autonegDonePin, // line logic: negotiation finished
    input wire logic farEndFaultPin, // line logic: remote fault level
    input wire logic jabberPin // line logic: jabber level
);
    import pls_pkg::*;

    // ========================================
    // condition inputs
    logic [PLS_COND_W-1:0] condRaw;
    logic [PLS_COND_W-1:0] condSync;
    logic [PLS_LATCH_W-1:0] latchCond;
    logic [PLS_LATCH_W-1:0] latched;
    logic readClear;

    always_comb begin
        condRaw[PLS_COND_LINK] = linkUpPin;
        condRaw[PLS_COND_ANEG] = autonegDonePin;
        condRaw[PLS_COND_FAULT] = farEndFaultPin;
        condRaw[PLS_COND_JABBER] = jabberPin;
        latchCond[PLS_LATCH_FAULT] = condSync[PLS_COND_FAULT];
        latchCond[PLS_LATCH_JABBER] = condSync[PLS_COND_JABBER];
    end

    pls_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async(condRaw),
        .sync(condSync)
    );

    pls_sticky u_sticky (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .cond(latchCond),
        .clear(readClear), // R7 R10 R12
        .latched(latched)
    );

    // ========================================
    // status word as software sees it
    logic [PLS_REG_W-1:0] linkWord;

    always_comb begin
        linkWord = PLS_FIXED_CAPS; // R2 R3 R4 R5 R8 R11
        linkWord[PLS_BIT_AUTONEG_DONE] = condSync[PLS_COND_ANEG]; // R6
        linkWord[PLS_BIT_FAR_END_FAULT] = latched[PLS_LATCH_FAULT]; // R7
        linkWord[PLS_BIT_LINK_UP] = condSync[PLS_COND_LINK]; // R9
        linkWord[PLS_BIT_JABBER] = latched[PLS_LATCH_JABBER]; // R10
    end

    // ========================================
    // avalon slave: fixed one wait cycle
    pls_bus_state_t state;
    pls_bus_state_t next_state;
    logic next_waitrequest;
    logic [PLS_DATA_W-1:0] next_readdata;
    logic accept;
    logic [PLS_DATA_W-1:0] readMux;
    logic [PLS_EVT_W-1:0] evtStatus;
    logic [PLS_EVT_W-1:0] evtMask;

    always_comb begin
        readMux = '0;
        case (address)
            PLS_ADDR_LINK_STATUS: begin
                readMux[PLS_REG_W-1:0] = linkWord; // R1
            end
            PLS_ADDR_EVT_STATUS: begin
                readMux[PLS_EVT_W-1:0] = evtStatus;
            end
            PLS_ADDR_EVT_MASK: begin
                readMux[PLS_EVT_W-1:0] = evtMask;
            end
            default: begin
                readMux = '0;
            end
        endcase
    end

    always_comb begin
        next_state = state;
        next_waitrequest = waitrequest;
        next_readdata = readdata;
        accept = 1'b0;
        if (ce) begin
            case (state)
                PLS_IDLE: begin
                    next_waitrequest = 1'b1;
                    if (read || write) begin
                        next_state = PLS_ANSWER;
                        next_waitrequest = 1'b0;
                        next_readdata = read ? readMux : '0;
                    end
                end
                PLS_ANSWER: begin
                    // master samples waitrequest low at this edge
                    accept = read || write;
                    next_state = PLS_IDLE;
                    next_waitrequest = 1'b1;
                end
                default: begin
                    next_state = PLS_IDLE;
                    next_waitrequest = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= PLS_IDLE;
            waitrequest <= 1'b1;
            readdata <= '0;
        end else begin
            state <= next_state;
            waitrequest <= next_waitrequest;
            readdata <= next_readdata;
        end
    end

    // clear at the edge that captures the word: no set lost in between
    always_comb begin
        readClear = ce && (state == PLS_IDLE) && read &&
            (address == PLS_ADDR_LINK_STATUS); // R12
    end

    // ========================================
    // interrupt events
    logic [PLS_COND_W-1:0] condPrev;
    logic [PLS_COND_W-1:0] next_condPrev;
    logic [PLS_EVT_W-1:0] events;
    logic [PLS_EVT_W-1:0] w1c;
    logic [PLS_EVT_W-1:0] next_evtStatus;
    logic [PLS_EVT_W-1:0] next_evtMask;
    logic next_irq;
    logic lowLane;

    always_comb begin
        events[PLS_EVT_ANEG_DONE] =
            condSync[PLS_COND_ANEG] & ~condPrev[PLS_COND_ANEG];
        events[PLS_EVT_FAULT] =
            condSync[PLS_COND_FAULT] & ~condPrev[PLS_COND_FAULT];
        events[PLS_EVT_JABBER] =
            condSync[PLS_COND_JABBER] & ~condPrev[PLS_COND_JABBER];
        events[PLS_EVT_LINK_CHANGE] =
            condSync[PLS_COND_LINK] ^ condPrev[PLS_COND_LINK];
        lowLane = accept && write && byteenable[0];
        w1c = '0;
        next_evtMask = evtMask;
        if (lowLane && (address == PLS_ADDR_EVT_STATUS)) begin
            w1c = writedata[PLS_EVT_W-1:0];
        end
        if (lowLane && (address == PLS_ADDR_EVT_MASK)) begin
            next_evtMask = writedata[PLS_EVT_W-1:0];
        end
        next_condPrev = condPrev;
        next_evtStatus = evtStatus;
        next_irq = irq;
        if (ce) begin
            next_condPrev = condSync;
            // an event in the clearing cycle survives
            next_evtStatus = (evtStatus & ~w1c) | events;
            next_irq = |(evtStatus & evtMask);
        end else begin
            next_evtMask = evtMask;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            condPrev <= '0;
            evtStatus <= PLS_EVT_RESET;
            evtMask <= PLS_EVT_RESET;
            irq <= 1'b0;
        end else begin
            condPrev <= next_condPrev;
            evtStatus <= next_evtStatus;
            evtMask <= next_evtMask;
            irq <= next_irq;
        end
    end
endmodule
`default_nettype wire

// >>> pls_pkg.sv
// constants and types of the phy link status register block
`default_nettype none
package pls_pkg;
    // ========================================
    // bus geometry
    localparam int PLS_ADDR_W = 8;
    localparam int PLS_DATA_W = 32;
    localparam int PLS_REG_W = 16;
    localparam int PLS_BE_W = 4;
    // ========================================
    // register indices; byte address is four times the index
    localparam logic [5:0] PLS_IDX_LINK_STATUS = 6'h01;
    localparam logic [5:0] PLS_IDX_EVT_STATUS = 6'h02;
    localparam logic [5:0] PLS_IDX_EVT_MASK = 6'h03;
    localparam logic [PLS_ADDR_W-1:0] PLS_ADDR_LINK_STATUS =
        {PLS_IDX_LINK_STATUS, 2'b00};
    localparam logic [PLS_ADDR_W-1:0] PLS_ADDR_EVT_STATUS =
        {PLS_IDX_EVT_STATUS, 2'b00};
    localparam logic [PLS_ADDR_W-1:0] PLS_ADDR_EVT_MASK =
        {PLS_IDX_EVT_MASK, 2'b00};
    // ========================================
    // phy_link_status layout
    localparam logic [PLS_REG_W-1:0] PLS_LINK_STATUS_RESET = 16'h7849;
    // constant capability bits: 14,13,12,11,6,3,0 set, reserved zero
    localparam logic [PLS_REG_W-1:0] PLS_FIXED_CAPS = 16'h7849;
    localparam int PLS_BIT_CAP_FAST_FULL_DUPLEX = 14;
    localparam int PLS_BIT_CAP_FAST_HALF_DUPLEX = 13;
    localparam int PLS_BIT_CAP_SLOW_FULL_DUPLEX = 12;
    localparam int PLS_BIT_CAP_SLOW_HALF_DUPLEX = 11;
    localparam int PLS_BIT_NO_PREAMBLE_OK = 6;
    localparam int PLS_BIT_AUTONEG_DONE = 5;
    localparam int PLS_BIT_FAR_END_FAULT = 4;
    localparam int PLS_BIT_AUTONEG_ABLE = 3;
    localparam int PLS_BIT_LINK_UP = 2;
    localparam int PLS_BIT_JABBER = 1;
    localparam int PLS_BIT_EXTENDED_REGS = 0;
    // ========================================
    // condition inputs after synchronising
    localparam int PLS_COND_W = 4;
    localparam int PLS_COND_LINK = 0;
    localparam int PLS_COND_ANEG = 1;
    localparam int PLS_COND_FAULT = 2;
    localparam int PLS_COND_JABBER = 3;
    // latched read-clear bits
    localparam int PLS_LATCH_W = 2;
    localparam int PLS_LATCH_FAULT = 0;
    localparam int PLS_LATCH_JABBER = 1;
    // ========================================
    // interrupt event bits, same layout in status and mask
    localparam int PLS_EVT_W = 4;
    localparam int PLS_EVT_ANEG_DONE = 0;
    localparam int PLS_EVT_FAULT = 1;
    localparam int PLS_EVT_JABBER = 2;
    localparam int PLS_EVT_LINK_CHANGE = 3;
    localparam logic [PLS_EVT_W-1:0] PLS_EVT_RESET = 4'h0;
    // ========================================
    typedef enum logic [1:0] {
        PLS_IDLE = 2'b01,
        PLS_ANSWER = 2'b10
    } pls_bus_state_t;
endpackage
`default_nettype wire

// >>> pls_sync.sv
// two-flop synchronisers for the phy condition levels
`default_nettype none
module pls_sync (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic ce, // clock enable
    input wire logic [pls_pkg::PLS_COND_W-1:0] async, // raw levels
    output logic [pls_pkg::PLS_COND_W-1:0] sync // synchronised levels
);
    import pls_pkg::*;

    logic [PLS_COND_W-1:0] stage;
    logic [PLS_COND_W-1:0] next_stage;
    logic [PLS_COND_W-1:0] next_sync;

    // ========================================
    // per-bit chain; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < PLS_COND_W; i++) begin : g_bit
            always_comb begin
                next_stage[i] = ce ? async[i] : stage[i];
                next_sync[i] = ce ? stage[i] : sync[i];
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    stage[i] <= 1'b0;
                    sync[i] <= 1'b0;
                end else begin
                    stage[i] <= next_stage[i];
                    sync[i] <= next_sync[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> pls_sticky.sv
// latched condition bits cleared by a read, set winning over clear
`default_nettype none
module pls_sticky (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic ce, // clock enable
    input wire logic [pls_pkg::PLS_LATCH_W-1:0] cond, // condition levels
    input wire logic clear, // read of the register first seen in PLS_IDLE
    output logic [pls_pkg::PLS_LATCH_W-1:0] latched // held bits
);
    import pls_pkg::*;

    logic [PLS_LATCH_W-1:0] next_latched;

    // ========================================
    genvar i;
    generate
        for (i = 0; i < PLS_LATCH_W; i++) begin : g_bit
            // a condition still present re-sets the bit at once
            always_comb begin
                next_latched[i] = latched[i];
                if (ce) begin
                    next_latched[i] = (latched[i] & ~clear) | cond[i];
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    latched[i] <= 1'b0;
                end else begin
                    latched[i] <= next_latched[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> pls_checker.sv
// port assertions for the phy link status register
`default_nettype none
module pls_checker
    import pls_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // reset, active low
    input wire logic ce, // clock enable
    input wire logic [PLS_ADDR_W-1:0] address, // byte address
    input wire logic read, // read request
    input wire logic write, // write request
    input wire logic [PLS_DATA_W-1:0] writedata, // write data
    input wire logic [PLS_BE_W-1:0] byteenable, // byte lanes
    input wire logic [PLS_DATA_W-1:0] readdata, // read data
    input wire logic waitrequest, // stall
    input wire logic irq, // interrupt
    input wire logic linkUpPin, // link level
    input wire logic autonegDonePin, // negotiation done
    input wire logic farEndFaultPin, // remote fault
    input wire logic jabberPin // jabber
);
    // ========================================
    // pin quiet time, so sync latency cannot make a false alarm;
    // counted on enabled cycles only, frozen sync flops lag the pins
    logic [3:0] pinsQ;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic rdOk;
    logic calm;
    assign rdOk = ce && read && !waitrequest &&
        address == PLS_ADDR_LINK_STATUS;
    assign calm = quiet >= 4'h6;
    always_comb begin
        next_quiet = quiet;
        if ({linkUpPin, autonegDonePin, farEndFaultPin, jabberPin} != pinsQ)
            next_quiet = 4'h0;
        else if (ce && quiet != 4'hf)
            next_quiet = quiet + 4'h1;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            quiet <= 4'h0;
            pinsQ <= 4'h0;
        end else begin
            quiet <= next_quiet;
            pinsQ <= {linkUpPin, autonegDonePin, farEndFaultPin, jabberPin};
        end
    end
    // ========================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_WAIT_PULSE: assert property (ce && !waitrequest ##1 ce |-> waitrequest)
        else $error("answer held longer than one cycle");
    AST_FAST_CAPS: assert property (rdOk |-> readdata[14:13] == 2'b11)
        else $error("fast capability bits wrong");
    AST_SLOW_CAPS: assert property (rdOk |-> readdata[12:11] == 2'b11)
        else $error("slow capability bits wrong");
    AST_RSVD_ZERO: assert property (rdOk |-> readdata[15] == 1'b0 &&
        readdata[10:7] == 4'h0 && readdata[31:16] == 16'h0000)
        else $error("reserved bits not zero");
    AST_NO_PREAMBLE: assert property (rdOk |-> readdata[6])
        else $error("preamble bit clear");
    AST_ANEG_ABLE: assert property (rdOk |-> readdata[3])
        else $error("negotiation ability clear");
    AST_EXT_REGS: assert property (rdOk |-> readdata[0])
        else $error("extended bit clear");
    AST_ANEG_DONE: assert property (rdOk && calm |-> readdata[5] == autonegDonePin)
        else $error("negotiation done bit wrong");
    AST_LINK_UP: assert property (rdOk && calm |-> readdata[2] == linkUpPin)
        else $error("link bit wrong");
    AST_FAULT_HELD: assert property (rdOk && calm && farEndFaultPin |-> readdata[4])
        else $error("fault bit lost while present");
    AST_JABBER_HELD: assert property (rdOk && calm && jabberPin |-> readdata[1])
        else $error("jabber bit lost while present");
endmodule
`default_nettype wire

// >>> pls_mgmt.sv
// management controller model: avalon-mm master of the status block
`default_nettype none
module pls_mgmt
    import pls_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic [PLS_DATA_W-1:0] readdata, // answer data
    input wire logic waitrequest, // slave stall
    output logic [PLS_ADDR_W-1:0] address, // byte address
    output logic read, // read request
    output logic write, // write request
    output logic [PLS_DATA_W-1:0] writedata, // write data
    output logic [PLS_BE_W-1:0] byteenable // byte lanes
);
    initial begin
        address <= 8'h00;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= 32'h0;
        byteenable <= 4'hf;
    end
    // idle sets how slowly the controller issues; bound cuts a hang
    task automatic xfer(input logic wr, input logic [PLS_ADDR_W-1:0] a,
        input logic [PLS_DATA_W-1:0] d, input int idle,
        input logic [PLS_BE_W-1:0] be,
        output logic [PLS_DATA_W-1:0] q, output logic ok);
        q = 32'h0;
        ok = 1'b0;
        repeat (idle + 1) @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        for (int n = 0; n < 20 && !ok; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) begin
                ok = 1'b1;
                q = readdata;
            end
        end
        read <= 1'b0;
        write <= 1'b0;
        address <= ~a;
        writedata <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> test_phy_status_register.sv
// self-checking bench of the phy link status register
`default_nettype none
module test_phy_status_register;
    import pls_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [PLS_ADDR_W-1:0] address;
    logic read, write, waitrequest, irq;
    logic [PLS_DATA_W-1:0] writedata, readdata, q;
    logic [PLS_BE_W-1:0] byteenable;
    logic linkUpPin = 1'b0, autonegDonePin = 1'b0;
    logic farEndFaultPin = 1'b0, jabberPin = 1'b0;
    int error_cnt = 0;
    int check_count = 0;
    pls_top dut (.clk(clk), .rst_n(rst_n), .ce(ce), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .linkUpPin(linkUpPin),
        .autonegDonePin(autonegDonePin), .farEndFaultPin(farEndFaultPin),
        .jabberPin(jabberPin));
    pls_mgmt mgmt (.clk(clk), .readdata(readdata),
        .waitrequest(waitrequest), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable));
    initial begin
        forever #2 clk = ~clk;
    end
    // ========================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic acc(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input int idle);
        acc_be(wr, a, d, idle, 4'hf);
    endtask
    task automatic acc_be(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input int idle, input logic [3:0] be);
        logic ok;
        mgmt.xfer(wr, a, d, idle, be, q, ok);
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t no answer", $time);
            finish_test();
        end
    endtask
    // pins: link, negotiation done, fault, jabber; sync needs 2 edges
    task automatic pins(input logic [3:0] p);
        @(posedge clk);
        {linkUpPin, autonegDonePin, farEndFaultPin, jabberPin} <= p;
        repeat (6) @(posedge clk);
    endtask
    // ========================================
    task automatic t_reset_value();
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h7849);
        acc(1'b1, PLS_ADDR_LINK_STATUS, 32'h0000ffff, 0);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 3);
        chk(q, 32'h7849);
        acc(1'b0, 8'h40, 32'h0, 0);
        chk(q, 32'h0);
    endtask
    task automatic t_link();
        pins(4'hc);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h786d);
        pins(4'h0);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h7849);
    endtask
    task automatic t_sticky();
        pins(4'h3);
        pins(4'h0);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h785b);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h7849);
        pins(4'h2);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h7859);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h7859);
        pins(4'h0);
    endtask
    task automatic t_irq();
        acc(1'b1, PLS_ADDR_EVT_MASK, 32'h2, 0);
        acc(1'b1, PLS_ADDR_EVT_STATUS, 32'hf, 0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        pins(4'h2);
        chk({31'h0, irq}, 32'h1);
        pins(4'h0);
        acc(1'b0, PLS_ADDR_EVT_STATUS, 32'h0, 0);
        chk(q, 32'h2);
        acc(1'b1, PLS_ADDR_EVT_STATUS, 32'h2, 0);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        pins(4'h1);
        chk({31'h0, irq}, 32'h0);
        acc(1'b0, PLS_ADDR_EVT_STATUS, 32'h0, 1);
        chk(q, 32'h4);
        pins(4'h0);
    endtask
    // lane 0 off: mask kept; frozen enable delays the link change past the first read
    task automatic t_freeze_lanes();
        acc_be(1'b1, PLS_ADDR_EVT_MASK, 32'hf, 0, 4'he);
        acc(1'b0, PLS_ADDR_EVT_MASK, 32'h0, 0);
        chk(q, 32'h2);
        ce <= 1'b0;
        pins(4'h8);
        ce <= 1'b1;
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h785b);
        acc(1'b0, PLS_ADDR_LINK_STATUS, 32'h0, 0);
        chk(q, 32'h784d);
        pins(4'h0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_value();
        t_link();
        t_sticky();
        t_irq();
        t_freeze_lanes();
        finish_test();
    end
endmodule
bind pls_top pls_checker chk_i (.clk(clk), .rst_n(rst_n), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .linkUpPin(linkUpPin),
    .autonegDonePin(autonegDonePin), .farEndFaultPin(farEndFaultPin),
    .jabberPin(jabberPin));
`default_nettype wire
